// >>> hdl/rcsc_pkg.sv
// shared constants and types of the radio command strobe controller
package rcsc_pkg;

  // ----------------------------------------------------------------
  // strobe codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNTH_ON_STROBE  = 8'h00;
  localparam logic [7:0] CALIBRATE_STROBE = 8'h01;
  localparam logic [7:0] RECEIVE_STROBE   = 8'h02;
  localparam logic [7:0] TRANSMIT_STROBE  = 8'h03;
  localparam logic [7:0] IDLE_STROBE      = 8'h04;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int CAL_TIME_US      = 2;
  localparam int CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;
  localparam int SETTLE_TIME_US   = 1;
  localparam int SETTLE_CYCLES    = SETTLE_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // radio states (one-hot)
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    RCSC_IDLE    = 8'h01,
    RCSC_CAL     = 8'h02,
    RCSC_SETTLE  = 8'h04,
    RCSC_FS_ON   = 8'h08,
    RCSC_RX      = 8'h10,
    RCSC_TX      = 8'h20,
    RCSC_FS_WAIT = 8'h40
  } rcsc_state_e;

  // target after calibration and settling
  typedef enum logic [2:0] {
    RCSC_GO_IDLE  = 3'h1,
    RCSC_GO_FS_ON = 3'h2,
    RCSC_GO_RX    = 3'h3,
    RCSC_GO_TX    = 3'h4
  } rcsc_goal_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } rcsc_strobe_s;

  typedef struct packed {
    logic [7:0] state;
    logic       synth_on;
    logic       calibrating;
    logic       cal_done;
    logic       cca_block;
  } rcsc_status_s;

endpackage

// >>> hdl/rcsc_timer.sv
// one-shot cycle counter for calibration and settling delays
`timescale 1ns/1ps
module rcsc_timer #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [WIDTH-1:0] cycles,
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             busy;
    logic             done;
  } rcsc_timer_s;

  rcsc_timer_s s_q;
  rcsc_timer_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (abort) begin
      s_d.busy = 1'b0;
    end else if (start) begin
      s_d.busy  = 1'b1;
      s_d.count = cycles;
    end else if (s_q.busy) begin
      if (s_q.count <= WIDTH'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.count = s_q.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule

// >>> hdl/rcsc_core.sv
// radio command strobe controller: strobe decode and radio state sequencing
//
// Functional notes
// - each one-byte strobe written by the cpu starts the matching internal radio sequence.
// - code 0x00 turns the synthesizer on, calibrating first when auto calibration is set.
// - code 0x00 in receive with clear-channel assessment active enters a synth-only wait state.
// - code 0x01 calibrates the synthesizer and then turns it off.
// - the calibrate strobe is accepted from idle even with auto calibration set.
// - code 0x02 enables receive, calibrating first from idle when auto calibration is set.
// - code 0x03 from idle enables transmit, calibrating first when auto calibration is set.
// - code 0x03 in receive with clear-channel assessment moves to transmit only if the channel is clear.
// - code 0x04 returns to idle with the synthesizer off from any state.
// - data buffer goes through a dedicated cpu port, configuration and status through mapped registers.
// - mapped registers report radio status back to the cpu.
// - a data transfer flag rises when a received byte is ready or a transmit byte can be accepted.
`timescale 1ns/1ps
module rcsc_core #(
  parameter int CAL_CYCLES    = rcsc_pkg::CAL_CYCLES,
  parameter int SETTLE_CYCLES = rcsc_pkg::SETTLE_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire rcsc_pkg::rcsc_strobe_s strobe,
  input  wire logic                   auto_calibrate_setting,
  input  wire logic                   cca_enable,
  input  wire logic                   channel_clear,
  input  wire logic                   data_wr,
  input  wire logic [7:0]             data_wdata,
  input  wire logic                   data_rd,
  input  wire logic                   rx_byte_valid,
  input  wire logic [7:0]             rx_byte,
  input  wire logic                   tx_byte_taken,
  output logic [7:0]                  radio_data_buffer_register,
  output logic                        tx_byte_valid,
  output logic [7:0]                  tx_byte,
  output logic                        radio_data_transfer_interrupt,
  output rcsc_pkg::rcsc_status_s      status,
  output logic                        synth_enable,
  output logic                        rx_enable,
  output logic                        tx_enable
);

  localparam int TW = 12;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rcsc_pkg::rcsc_state_e state;
    rcsc_pkg::rcsc_goal_e  goal;
    logic [7:0]            rx_data;
    logic                  rx_full;
    logic [7:0]            tx_data;
    logic                  tx_full;
    logic                  xfer_flag;
    logic                  cal_done;
    logic                  cca_block;
    rcsc_pkg::rcsc_status_s status;
    logic                  synth;
    logic                  rx_en;
    logic                  tx_en;
  } rcsc_core_s;

  rcsc_core_s s_q;
  rcsc_core_s s_d;

  logic          timer_done;
  logic          timer_start;
  logic [TW-1:0] timer_cycles;
  logic          timer_abort;

  rcsc_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (timer_start),
    .abort   (timer_abort),
    .cycles  (timer_cycles),
    .done    (timer_done)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic rcsc_pkg::rcsc_state_e goal_state(input rcsc_pkg::rcsc_goal_e g);
    case (g)
      rcsc_pkg::RCSC_GO_FS_ON: goal_state = rcsc_pkg::RCSC_FS_ON;
      rcsc_pkg::RCSC_GO_RX:    goal_state = rcsc_pkg::RCSC_RX;
      rcsc_pkg::RCSC_GO_TX:    goal_state = rcsc_pkg::RCSC_TX;
      default:                 goal_state = rcsc_pkg::RCSC_IDLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.cal_done = 1'b0;
    timer_start  = 1'b0;
    timer_abort  = 1'b0;
    timer_cycles = TW'(SETTLE_CYCLES);

    if (strobe.valid) begin
      case (strobe.code)
        rcsc_pkg::SYNTH_ON_STROBE: begin
          if (s_q.state == rcsc_pkg::RCSC_RX && cca_enable) begin
            s_d.state = rcsc_pkg::RCSC_FS_WAIT;
          end else if (s_q.state == rcsc_pkg::RCSC_IDLE) begin
            // synthesizer on, calibrate first if auto
            s_d.goal     = rcsc_pkg::RCSC_GO_FS_ON;
            s_d.state    = auto_calibrate_setting ? rcsc_pkg::RCSC_CAL : rcsc_pkg::RCSC_SETTLE;
            timer_start  = 1'b1;
            timer_cycles = auto_calibrate_setting ? TW'(CAL_CYCLES) : TW'(SETTLE_CYCLES);
          end
        end
        rcsc_pkg::CALIBRATE_STROBE: begin
          // calibrate then off, regardless of auto setting
          if (s_q.state == rcsc_pkg::RCSC_IDLE) begin
            s_d.goal     = rcsc_pkg::RCSC_GO_IDLE;
            s_d.state    = rcsc_pkg::RCSC_CAL;
            timer_start  = 1'b1;
            timer_cycles = TW'(CAL_CYCLES);
          end
        end
        rcsc_pkg::RECEIVE_STROBE: begin
          // receive, calibrating first from idle if auto
          if (s_q.state == rcsc_pkg::RCSC_IDLE) begin
            s_d.goal     = rcsc_pkg::RCSC_GO_RX;
            s_d.state    = auto_calibrate_setting ? rcsc_pkg::RCSC_CAL : rcsc_pkg::RCSC_SETTLE;
            timer_start  = 1'b1;
            timer_cycles = auto_calibrate_setting ? TW'(CAL_CYCLES) : TW'(SETTLE_CYCLES);
          end else if (s_q.state == rcsc_pkg::RCSC_FS_ON || s_q.state == rcsc_pkg::RCSC_FS_WAIT ||
                       s_q.state == rcsc_pkg::RCSC_TX) begin
            s_d.state = rcsc_pkg::RCSC_RX;
          end
        end
        rcsc_pkg::TRANSMIT_STROBE: begin
          if (s_q.state == rcsc_pkg::RCSC_IDLE) begin
            s_d.goal     = rcsc_pkg::RCSC_GO_TX;
            s_d.state    = auto_calibrate_setting ? rcsc_pkg::RCSC_CAL : rcsc_pkg::RCSC_SETTLE;
            timer_start  = 1'b1;
            timer_cycles = auto_calibrate_setting ? TW'(CAL_CYCLES) : TW'(SETTLE_CYCLES);
          end else if (s_q.state == rcsc_pkg::RCSC_RX) begin
            if (!cca_enable || channel_clear) begin
              s_d.state = rcsc_pkg::RCSC_TX;
            end else begin
              s_d.cca_block = 1'b1;
            end
          end else if (s_q.state == rcsc_pkg::RCSC_FS_ON || s_q.state == rcsc_pkg::RCSC_FS_WAIT) begin
            s_d.state = rcsc_pkg::RCSC_TX;
          end
        end
        rcsc_pkg::IDLE_STROBE: begin
          // idle from anywhere, abort any sequence
          s_d.state   = rcsc_pkg::RCSC_IDLE;
          timer_abort = 1'b1;
        end
        default: begin
          s_d.state = s_q.state;
        end
      endcase
    end

    // an ignored strobe must not swallow the timer completion, else the sequence would hang
    if (timer_done && !timer_abort && s_d.state == s_q.state) begin
      case (s_q.state)
        rcsc_pkg::RCSC_CAL: begin
          s_d.cal_done = 1'b1;
          if (s_q.goal == rcsc_pkg::RCSC_GO_IDLE) begin
            s_d.state = rcsc_pkg::RCSC_IDLE;
          end else begin
            s_d.state   = rcsc_pkg::RCSC_SETTLE;
            timer_start = 1'b1;
          end
        end
        rcsc_pkg::RCSC_SETTLE: s_d.state = goal_state(s_q.goal);
        default:               s_d.state = s_q.state;
      endcase
    end

    if (s_d.state != rcsc_pkg::RCSC_RX) begin
      s_d.cca_block = 1'b0;
    end

    if (rx_byte_valid) begin
      s_d.rx_data = rx_byte;
      s_d.rx_full = 1'b1;
    end else if (data_rd) begin
      s_d.rx_full = 1'b0;
    end
    if (data_wr) begin
      s_d.tx_data = data_wdata;
      s_d.tx_full = 1'b1;
    end else if (tx_byte_taken) begin
      s_d.tx_full = 1'b0;
    end

    // flag up while an rx byte waits in receive or the tx slot is free in transmit
    s_d.xfer_flag = (s_d.rx_full && s_d.state == rcsc_pkg::RCSC_RX) ||
                    (!s_d.tx_full && s_d.state == rcsc_pkg::RCSC_TX);

    s_d.synth = s_d.state != rcsc_pkg::RCSC_IDLE;
    s_d.rx_en = s_d.state == rcsc_pkg::RCSC_RX;
    s_d.tx_en = s_d.state == rcsc_pkg::RCSC_TX;

    s_d.status.state       = s_d.state;
    s_d.status.synth_on    = s_d.synth;
    s_d.status.calibrating = s_d.state == rcsc_pkg::RCSC_CAL;
    s_d.status.cal_done    = s_d.cal_done;
    s_d.status.cca_block   = s_d.cca_block;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.state <= rcsc_pkg::RCSC_IDLE;
      s_q.goal  <= rcsc_pkg::RCSC_GO_IDLE;
      s_q.status.state <= rcsc_pkg::RCSC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign radio_data_buffer_register    = s_q.rx_data;
  assign tx_byte_valid                 = s_q.tx_full;
  assign tx_byte                       = s_q.tx_data;
  assign radio_data_transfer_interrupt = s_q.xfer_flag;
  assign status                        = s_q.status;
  assign synth_enable                  = s_q.synth;
  assign rx_enable                     = s_q.rx_en;
  assign tx_enable                     = s_q.tx_en;

endmodule

// >>> tb/rcsc_core_sva.sv
// port-level assertions of the radio command strobe controller
`timescale 1ns/1ps
module rcsc_core_sva #(
  parameter int CAL_CYCLES    = 100,
  parameter int SETTLE_CYCLES = 50
) (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire rcsc_pkg::rcsc_strobe_s strobe,
  input wire logic                   auto_calibrate_setting,
  input wire logic                   cca_enable,
  input wire logic                   channel_clear,
  input wire rcsc_pkg::rcsc_status_s status,
  input wire logic                   synth_enable,
  input wire logic                   rx_enable,
  input wire logic                   tx_enable,
  input wire logic                   radio_data_transfer_interrupt
);
  // calibration bound allows the calibration count plus the settling count plus a few register stages
  localparam int CAL_MAX = CAL_CYCLES + SETTLE_CYCLES + 8;
  logic [7:0] st;
  logic [7:0] cd;
  logic       go;
  assign st = status.state;
  assign cd = strobe.code;
  assign go = strobe.valid;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_cal_run;
    st == rcsc_pkg::RCSC_CAL && synth_enable;
  endsequence
  sequence s_cal_off;
    st == rcsc_pkg::RCSC_IDLE && !synth_enable;
  endsequence
  a_idle_any_state: assert property (go && cd == 8'h04 |=> s_cal_off) else $error("idle strobe missed");
  a_nop_no_change: assert property (
    go && cd > 8'h04 && st inside {8'h01, 8'h10, 8'h20} |=> st == $past(st)) else $error("no-op strobe moved state");
  a_rx_cal_first: assert property (
    go && cd == 8'h02 && st == rcsc_pkg::RCSC_IDLE && auto_calibrate_setting |=> s_cal_run)
    else $error("receive skipped calibration");
  a_cal_then_off: assert property (
    go && cd == 8'h01 && st == rcsc_pkg::RCSC_IDLE |=> s_cal_run ##[1:CAL_MAX] s_cal_off)
    else $error("calibrate strobe did not end off");
  a_tx_cca_held: assert property (
    go && cd == 8'h03 && st == rcsc_pkg::RCSC_RX && cca_enable && !channel_clear
    |=> st == rcsc_pkg::RCSC_RX && status.cca_block) else $error("busy channel not held");
  a_tx_cca_clear: assert property (
    go && cd == 8'h03 && st == rcsc_pkg::RCSC_RX && cca_enable && channel_clear |=> st == rcsc_pkg::RCSC_TX)
    else $error("clear channel not sent");
  a_synth_wait: assert property (
    go && cd == 8'h00 && st == rcsc_pkg::RCSC_RX && cca_enable |=> st == rcsc_pkg::RCSC_FS_WAIT && synth_enable)
    else $error("wait state missed");
  a_cal_synth_on: assert property (st == rcsc_pkg::RCSC_CAL |-> synth_enable && status.calibrating)
    else $error("calibration without synth");
  a_cal_ends: assert property (st == rcsc_pkg::RCSC_CAL |-> ##[1:CAL_MAX] st != rcsc_pkg::RCSC_CAL)
    else $error("calibration never ended");
  a_tx_enable_st: assert property (tx_enable |-> st == rcsc_pkg::RCSC_TX) else $error("tx outside transmit");
  a_int_quiet: assert property (radio_data_transfer_interrupt |-> st inside {8'h10, 8'h20})
    else $error("transfer flag outside rx tx");
endmodule
bind rcsc_core rcsc_core_sva #(.CAL_CYCLES(CAL_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .strobe(strobe), .auto_calibrate_setting(auto_calibrate_setting),
  .cca_enable(cca_enable), .channel_clear(channel_clear), .status(status), .synth_enable(synth_enable),
  .rx_enable(rx_enable), .tx_enable(tx_enable), .radio_data_transfer_interrupt(radio_data_transfer_interrupt));

// >>> tb/rcsc_radio_model.sv
// radio side model: delivers received bytes, consumes transmit bytes slowly
`timescale 1ns/1ps
module rcsc_radio_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       rx_enable,
  input  wire logic       tx_enable,
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_byte_taken,
  output logic [7:0]      last_tx
);
  int wait_n;
  // idle data lines toggle so a stale byte is never mistaken for a fresh one
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_byte_valid <= 1'b0;
      rx_byte <= 8'h5a;
      tx_byte_taken <= 1'b0;
      wait_n <= 0;
      last_tx <= 8'h00;
    end else begin
      rx_byte_valid <= send && rx_enable;
      rx_byte <= (send && rx_enable) ? send_byte : ~rx_byte;
      tx_byte_taken <= 1'b0;
      if (tx_enable && tx_byte_valid && !tx_byte_taken) begin
        wait_n <= (wait_n == 3) ? 0 : wait_n + 1;
        tx_byte_taken <= (wait_n == 3);
        if (wait_n == 3) last_tx <= tx_byte;
      end
    end
  end
endmodule

// >>> tb/tb_radio_command_strobe_control.sv
// self-checking bench of the radio command strobe controller
`timescale 1ns/1ps
module tb_radio_command_strobe_control;
  typedef struct packed {logic ac; logic [7:0] code; logic [7:0] first; logic [7:0] last; logic syn;} rcsc_row_s;
  logic clk, sys_rst, ac, cca, clr, wr, rd, send, rxv, taken, txv, xint, syn, rxe, txe;
  logic [7:0] wdata, sbyte, rxb, rbuf, txb, last_tx;
  rcsc_pkg::rcsc_strobe_s strobe;
  rcsc_pkg::rcsc_status_s status;
  int bad_count, cmp_count, cal_seen, n0;
  // first is the state shown two cycles after the strobe
  rcsc_row_s rows [12] = '{'{1, 8'h00, 8'h02, 8'h08, 1}, '{0, 8'h00, 8'h04, 8'h08, 1}, '{1, 8'h01, 8'h02, 8'h01, 0},
    '{0, 8'h01, 8'h02, 8'h01, 0}, '{1, 8'h02, 8'h02, 8'h10, 1}, '{0, 8'h02, 8'h04, 8'h10, 1},
    '{1, 8'h03, 8'h02, 8'h20, 1}, '{0, 8'h03, 8'h04, 8'h20, 1}, '{1, 8'h04, 8'h01, 8'h01, 0},
    '{1, 8'h05, 8'h01, 8'h01, 0}, '{0, 8'h80, 8'h01, 8'h01, 0}, '{1, 8'hff, 8'h01, 8'h01, 0}};
  rcsc_core #(.CAL_CYCLES(4), .SETTLE_CYCLES(3)) uut (.clk(clk), .sys_rst(sys_rst), .strobe(strobe),
    .auto_calibrate_setting(ac), .cca_enable(cca), .channel_clear(clr), .data_wr(wr), .data_wdata(wdata),
    .data_rd(rd), .rx_byte_valid(rxv), .rx_byte(rxb), .tx_byte_taken(taken), .radio_data_buffer_register(rbuf),
    .tx_byte_valid(txv), .tx_byte(txb), .radio_data_transfer_interrupt(xint), .status(status),
    .synth_enable(syn), .rx_enable(rxe), .tx_enable(txe));
  rcsc_radio_model radio (.clk(clk), .sys_rst(sys_rst), .rx_enable(rxe), .tx_enable(txe), .send(send),
    .send_byte(sbyte), .tx_byte_valid(txv), .tx_byte(txb), .rx_byte_valid(rxv), .rx_byte(rxb),
    .tx_byte_taken(taken), .last_tx(last_tx));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hit(input logic [7:0] code);
    strobe = '{1'b1, code};
    @(negedge clk);
    strobe.valid = 1'b0;
    // a quiet cycle keeps back-to-back strobes from rewriting valid in one step
    @(negedge clk);
  endtask
  // calibration plus settling is nine cycles with the short counts
  task automatic settle();
    repeat (20) @(negedge clk);
  endtask
  task automatic wait_int(input logic lvl);
    int n;
    for (n = 0; n < 20 && xint !== lvl; n++) @(negedge clk);
    if (xint !== lvl) begin
      bad_count++;
      $display("[FAIL] %0t transfer flag wait ran out", $time);
      close_out();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (status.cal_done === 1'b1) cal_seen++;
  initial begin
    {sys_rst, ac, cca, clr, wr, rd, send, wdata, sbyte, strobe} = '0;
    sys_rst = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    check(status.state, 8'h01);
    sys_rst = 1'b0;
    // --------------------------------------------------------------
    // table of strobes from idle
    // --------------------------------------------------------------
    foreach (rows[i]) begin
      hit(8'h04);
      settle();
      ac = rows[i].ac;
      n0 = cal_seen;
      hit(rows[i].code);
      check(status.state, rows[i].first);
      check(status.calibrating, rows[i].first == 8'h02);
      settle();
      check(status.state, rows[i].last);
      check(syn, rows[i].syn);
      check(status.synth_on, rows[i].syn);
      check(rxe, rows[i].last == 8'h10);
      check(txe, rows[i].last == 8'h20);
      check(8'(cal_seen - n0), 8'(rows[i].first == 8'h02));
    end
    ac = 1'b0;
    hit(8'h02);
    settle();
    cca = 1'b1;
    hit(8'h03);
    check(status.state, 8'h10);
    check(status.cca_block, 1'b1);
    clr = 1'b1;
    hit(8'h03);
    check(status.state, 8'h20);
    hit(8'h02);
    settle();
    hit(8'h00);
    check(status.state, 8'h40);
    cca = 1'b0;
    hit(8'h04);
    ac = 1'b1;
    hit(8'h02);
    @(negedge clk);
    hit(8'h04);
    check(status.state, 8'h01);
    settle();
    check(status.state, 8'h01);
    hit(8'h02);
    repeat (3) @(negedge clk);
    // no-op landing on the calibration end must not freeze it
    hit(8'h80);
    check(status.state, 8'h04);
    settle();
    check(status.state, 8'h10);
    hit(8'h04);
    ac = 1'b0;
    hit(8'h02);
    settle();
    hit(8'h7f);
    check(status.state, 8'h10);
    sbyte = 8'ha5;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    wait_int(1'b1);
    check(rbuf, 8'ha5);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    wait_int(1'b0);
    hit(8'h03);
    settle();
    wait_int(1'b1);
    wdata = 8'h3c;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wait_int(1'b0);
    wait_int(1'b1);
    check(last_tx, 8'h3c);
    sys_rst = 1'b1;
    @(negedge clk);
    check(status.state, 8'h01);
    check(txe, 1'b0);
    check(syn, 1'b0);
    check(xint, 1'b0);
    check(txv, 1'b0);
    close_out();
  end
endmodule
